// File: src/tsf_regs.vh
// Purpose: Shared constants for the T1 superframe framer and line coder
// Assumes: Included by bare name from every design file
// Notes: Definitions only
`ifndef TSF_REGS_VH
`define TSF_REGS_VH

// Frame geometry
`define TSF_SLOTS 24
`define TSF_SLOT_BITS 8
`define TSF_FRAME_BITS 193
`define TSF_FBIT_POS 8'hc0
`define TSF_SF_FRAMES 12
`define TSF_LAST_FRAME 4'hb
`define TSF_RBS_FRAME_A 4'h5
`define TSF_RBS_FRAME_B 4'hb

// Superframe F-bit sequence, frame 0 in the MSB
`define TSF_SF_PATTERN 12'h8dc

// Timing: frame rate in frames per second, core clock in kHz
`define TSF_FRAME_RATE 8000
`define TSF_CLK_KHZ 250000

// Line symbol codes used in the 8-symbol windows
`define TSF_SYM_ZERO 2'h0
`define TSF_SYM_B 2'h1
`define TSF_SYM_V 2'h2
`define TSF_SYM_POS 2'h1
`define TSF_SYM_NEG 2'h2
`define TSF_SYM_SUB 2'h3

// Zero-substitution block, oldest symbol in the top pair: 000VB0VB
`define TSF_B8ZS_BLOCK 16'h0249

// Longest zero run allowed in plain mark-inversion mode
`define TSF_MAX_ZEROS 7

// Sync loss threshold on F-bit errors per superframe
`define TSF_FERR_LIMIT 2'h2

`endif

// File: src/tsf_line_enc.v
// Purpose: Mark-inversion line encoder with optional eight-zero substitution
// Assumes: i_bit_en pulses once per line bit; i_bit valid with it
// Notes: Eight-bit latency; o_pos/o_neg held for the whole bit period
`timescale 1ns/1ps
`include "tsf_regs.vh"

module tsf_line_enc (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_bit_en,
  input wire i_bit,
  input wire i_b8zs_en,
  output reg o_pos,
  output reg o_neg
);

  reg [15:0] q_r;
  reg last_pos_r;
  reg [15:0] q_nxt;
  reg in_bit;
  reg [1:0] out_sym;
  reg fill_pulse;

  always @* begin
    // Seven pulseless symbols queued: force a mark to hold ones density
    fill_pulse = !i_b8zs_en && (q_r[13:0] == 14'h0000);
    in_bit = i_bit | fill_pulse;
    q_nxt = {q_r[13:0], (in_bit ? `TSF_SYM_B : `TSF_SYM_ZERO)};
    if (i_b8zs_en && (q_nxt == 16'h0000)) begin
      q_nxt = `TSF_B8ZS_BLOCK;
    end
    out_sym = q_r[15:14];
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q_r <= 16'h0000;
      last_pos_r <= 1'b0;
      o_pos <= 1'b0;
      o_neg <= 1'b0;
    end else if (i_bit_en) begin
      q_r <= q_nxt;
      case (out_sym)
        `TSF_SYM_B: begin
          // Normal mark opposes the previous mark
          o_pos <= !last_pos_r;
          o_neg <= last_pos_r;
          last_pos_r <= !last_pos_r;
        end
        `TSF_SYM_V: begin
          // Violation repeats the previous polarity
          o_pos <= last_pos_r;
          o_neg <= !last_pos_r;
        end
        default: begin
          o_pos <= 1'b0;
          o_neg <= 1'b0;
        end
      endcase
    end
  end

endmodule // tsf_line_enc

// File: src/tsf_framer.v
// Purpose: T1 superframe framer, robbed-bit signaling and line coding
// Assumes: Line bits paced from the core clock; receive pins at same bit rate
// Notes: Operation
`timescale 1ns/1ps
`include "tsf_regs.vh"

module tsf_framer #(
  parameter integer FRAME_RATE = `TSF_FRAME_RATE,
  parameter integer CLK_KHZ = `TSF_CLK_KHZ
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_b8zs_en,
  input wire i_rbs_en,
  input wire i_tx_56k,
  input wire [7:0] i_tx_ts_data,
  input wire i_tx_sig,
  input wire i_rx_pos,
  input wire i_rx_neg,
  output wire o_line_pos,
  output wire o_line_neg,
  output reg o_tx_ts_req,
  output reg [4:0] o_tx_ts_num,
  output reg [3:0] o_tx_frame_num,
  output reg [7:0] o_rx_data,
  output reg o_rx_valid,
  output reg [4:0] o_rx_ts_num,
  output reg [3:0] o_rx_frame_num,
  output reg o_rx_sig,
  output reg o_rx_sync,
  output reg o_rx_bpv
);

  // Line rate in kHz derived from frame rate and frame length
  localparam integer LINE_KHZ = (FRAME_RATE * `TSF_FRAME_BITS) / 1000;
  localparam [17:0] ACC_STEP = LINE_KHZ[17:0];
  localparam [17:0] ACC_MOD = CLK_KHZ[17:0];

  // ---------------- Bit-rate enable ----------------
  reg [17:0] acc_r;
  reg bit_tick_r;
  wire [18:0] acc_sum = {1'b0, acc_r} + {1'b0, ACC_STEP};

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_r <= 18'h00000;
      bit_tick_r <= 1'b0;
    end else if (acc_sum >= {1'b0, ACC_MOD}) begin
      acc_r <= acc_sum[17:0] - ACC_MOD;
      bit_tick_r <= 1'b1;
    end else begin
      acc_r <= acc_sum[17:0];
      bit_tick_r <= 1'b0;
    end
  end

  // ---------------- Transmit framer ----------------
  reg [7:0] tx_pos_r;
  reg [3:0] tx_frm_r;
  reg [7:0] tx_byte_r;
  reg tx_bit;
  wire [11:0] sf_pat = `TSF_SF_PATTERN;
  wire tx_rbs_frame = (tx_frm_r == `TSF_RBS_FRAME_A) || (tx_frm_r == `TSF_RBS_FRAME_B);
  wire tx_at_f = (tx_pos_r == `TSF_FBIT_POS);
  wire [7:0] tx_pos_inc = tx_pos_r + 8'h01;
  wire [3:0] tx_frm_inc = (tx_frm_r == `TSF_LAST_FRAME) ? 4'h0 : tx_frm_r + 4'h1;

  always @* begin
    if (tx_at_f) begin
      tx_bit = sf_pat[4'hb - tx_frm_r];
    end else begin
      tx_bit = tx_byte_r[3'h7 - tx_pos_r[2:0]];
    end
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_pos_r <= 8'h00;
      tx_frm_r <= 4'h0;
      o_tx_ts_req <= 1'b0;
      o_tx_ts_num <= 5'h00;
      o_tx_frame_num <= 4'h0;
    end else begin
      o_tx_ts_req <= 1'b0;
      if (bit_tick_r) begin
        if (tx_at_f) begin
          // Next frame starts right after the F bit
          tx_pos_r <= 8'h00;
          tx_frm_r <= tx_frm_inc;
          o_tx_ts_req <= 1'b1;
          o_tx_ts_num <= 5'h00;
          o_tx_frame_num <= tx_frm_inc;
        end else begin
          tx_pos_r <= tx_pos_inc;
          if (tx_pos_r[2:0] == 3'h7 && tx_pos_inc != `TSF_FBIT_POS) begin
            o_tx_ts_req <= 1'b1;
            o_tx_ts_num <= tx_pos_inc[7:3];
            o_tx_frame_num <= tx_frm_r;
          end
        end
      end
    end
  end

  // Slot byte is taken in the request cycle
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_byte_r <= 8'h00;
    end else if (o_tx_ts_req) begin
      tx_byte_r[7:1] <= i_tx_ts_data[7:1];
      if (i_rbs_en && ((o_tx_frame_num == `TSF_RBS_FRAME_A) ||
                       (o_tx_frame_num == `TSF_RBS_FRAME_B))) begin
        tx_byte_r[0] <= i_tx_sig;
      end else if (i_tx_56k) begin
        tx_byte_r[0] <= 1'b1;
      end else begin
        tx_byte_r[0] <= i_tx_ts_data[0];
      end
    end
  end

  tsf_line_enc u_enc (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_bit_en(bit_tick_r),
    .i_bit(tx_bit),
    .i_b8zs_en(i_b8zs_en),
    .o_pos(o_line_pos),
    .o_neg(o_line_neg)
  );

  // ---------------- Receive line decoder ----------------
  reg [1:0] rx_pos_s_r;
  reg [1:0] rx_neg_s_r;
  reg [15:0] rw_r;
  reg rx_last_pos_r;
  reg [15:0] rw_nxt;
  reg [1:0] in_sym;
  reg [1:0] xs;
  reg sub_hit;
  wire [1:0] old_sym = rw_r[15:14];
  wire rbit = (old_sym == `TSF_SYM_POS) || (old_sym == `TSF_SYM_NEG);

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_pos_s_r <= 2'b00;
      rx_neg_s_r <= 2'b00;
    end else begin
      rx_pos_s_r <= {rx_pos_s_r[0], i_rx_pos};
      rx_neg_s_r <= {rx_neg_s_r[0], i_rx_neg};
    end
  end

  always @* begin
    case ({rx_pos_s_r[1], rx_neg_s_r[1]})
      2'b10: in_sym = `TSF_SYM_POS;
      2'b01: in_sym = `TSF_SYM_NEG;
      default: in_sym = `TSF_SYM_ZERO;
    endcase
    rw_nxt = {rw_r[13:0], in_sym};
    xs = rw_nxt[9:8];
    // 0 0 0 X -X 0 -X X, oldest first
    sub_hit = i_b8zs_en && (rw_nxt[15:10] == 6'h00) && (rw_nxt[5:4] == 2'h0) &&
              (xs == `TSF_SYM_POS || xs == `TSF_SYM_NEG) &&
              (rw_nxt[7:6] == ~xs) && (rw_nxt[3:2] == ~xs) && (rw_nxt[1:0] == xs);
    if (sub_hit) begin
      rw_nxt = {8{`TSF_SYM_SUB}};
    end
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rw_r <= 16'h0000;
      rx_last_pos_r <= 1'b0;
      o_rx_bpv <= 1'b0;
    end else begin
      o_rx_bpv <= 1'b0;
      if (bit_tick_r) begin
        rw_r <= rw_nxt;
        if (old_sym == `TSF_SYM_POS) begin
          o_rx_bpv <= rx_last_pos_r;
          rx_last_pos_r <= 1'b1;
        end else if (old_sym == `TSF_SYM_NEG) begin
          o_rx_bpv <= !rx_last_pos_r;
          rx_last_pos_r <= 1'b0;
        end
        if (sub_hit) begin
          // Block ends on a mark of polarity X
          rx_last_pos_r <= (xs == `TSF_SYM_POS);
        end
      end
    end
  end

  // ---------------- Receive framer ----------------
  reg [7:0] rx_bpos_r;
  reg [3:0] rx_frm_r;
  reg [11:0] rx_fhist_r;
  reg [3:0] rx_fcnt_r;
  reg [1:0] rx_ferr_r;
  reg [6:0] rx_sh_r;
  reg hunt_hit;
  reg [3:0] hunt_frm;
  reg [23:0] pat2;
  reg [11:0] rot;
  integer k;
  wire [11:0] fhist_nxt = {rx_fhist_r[10:0], rbit};
  wire rx_at_f = (rx_bpos_r == `TSF_FBIT_POS);
  wire rx_exp_f = sf_pat[4'hb - rx_frm_r];
  wire [3:0] rx_frm_inc = (rx_frm_r == `TSF_LAST_FRAME) ? 4'h0 : rx_frm_r + 4'h1;
  wire [7:0] rx_bpos_inc = rx_bpos_r + 8'h01;
  wire rx_rbs_frame = (rx_frm_r == `TSF_RBS_FRAME_A) || (rx_frm_r == `TSF_RBS_FRAME_B);

  // Which frame the newest F bit belongs to, if the history is a rotation
  always @* begin
    hunt_hit = 1'b0;
    hunt_frm = 4'h0;
    pat2 = {`TSF_SF_PATTERN, `TSF_SF_PATTERN};
    rot = 12'h000;
    for (k = 0; k < `TSF_SF_FRAMES; k = k + 1) begin
      rot = pat2[23 - ((k + 1) % `TSF_SF_FRAMES) -: 12];
      if (fhist_nxt == rot) begin
        hunt_hit = 1'b1;
        hunt_frm = k[3:0];
      end
    end
  end

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_bpos_r <= 8'h00;
      rx_frm_r <= 4'h0;
      rx_fhist_r <= 12'h000;
      rx_fcnt_r <= 4'h0;
      rx_ferr_r <= 2'h0;
      rx_sh_r <= 7'h00;
      o_rx_sync <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_ts_num <= 5'h00;
      o_rx_frame_num <= 4'h0;
      o_rx_sig <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (bit_tick_r) begin
        if (rx_at_f) begin
          rx_bpos_r <= 8'h00;
          rx_frm_r <= rx_frm_inc;
          if (o_rx_sync) begin
            if (rbit != rx_exp_f) begin
              if (rx_ferr_r + 2'h1 == `TSF_FERR_LIMIT) begin
                o_rx_sync <= 1'b0;
                rx_fcnt_r <= 4'h0;
                rx_ferr_r <= 2'h0;
              end else begin
                rx_ferr_r <= rx_ferr_r + 2'h1;
              end
            end else if (rx_frm_r == `TSF_LAST_FRAME) begin
              rx_ferr_r <= 2'h0;
            end
          end else begin
            rx_fhist_r <= fhist_nxt;
            if (rx_fcnt_r != `TSF_LAST_FRAME) begin
              rx_fcnt_r <= rx_fcnt_r + 4'h1;
            end else if (hunt_hit) begin
              o_rx_sync <= 1'b1;
              rx_frm_r <= (hunt_frm == `TSF_LAST_FRAME) ? 4'h0 : hunt_frm + 4'h1;
              rx_ferr_r <= 2'h0;
            end else begin
              // Slip one bit and restart the collection
              rx_bpos_r <= rx_bpos_r;
              rx_fcnt_r <= 4'h0;
            end
          end
        end else begin
          rx_bpos_r <= rx_bpos_inc;
          rx_sh_r <= {rx_sh_r[5:0], rbit};
          if (rx_bpos_r[2:0] == 3'h7) begin
            o_rx_valid <= o_rx_sync;
            o_rx_data <= {rx_sh_r, rbit};
            o_rx_ts_num <= rx_bpos_r[7:3];
            o_rx_frame_num <= rx_frm_r;
            o_rx_sig <= i_rbs_en && rx_rbs_frame && rbit;
          end
        end
      end
    end
  end

endmodule // tsf_framer

// File: dv/tsf_framer_assertions.sv
// Purpose: Port checker for the T1 superframe framer
// Assumes: Sees only the top module ports
// Notes: Bound to every tsf_framer instance
`timescale 1ns/1ps
module tsf_framer_sva (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_rbs_en,
  input wire o_line_pos,
  input wire o_line_neg,
  input wire o_tx_ts_req,
  input wire [4:0] o_tx_ts_num,
  input wire [3:0] o_tx_frame_num,
  input wire o_rx_valid,
  input wire [4:0] o_rx_ts_num,
  input wire [3:0] o_rx_frame_num,
  input wire o_rx_sig,
  input wire o_rx_sync
);
  reg [4:0] ls_r;
  reg [3:0] lf_r;
  reg seen_r;
  // Last requested slot and frame
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ls_r <= 5'h00;
      lf_r <= 4'h0;
      seen_r <= 1'b0;
    end else if (o_tx_ts_req) begin
      ls_r <= o_tx_ts_num;
      lf_r <= o_tx_frame_num;
      seen_r <= 1'b1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_line_excl: assert property (!(o_line_pos && o_line_neg))
    else $error("both line pins high");
  a_req_pulse: assert property (o_tx_ts_req |=> !o_tx_ts_req)
    else $error("slot request longer than one cycle");
  a_slot_seq: assert property (o_tx_ts_req && seen_r |->
    o_tx_ts_num == ((ls_r == 5'h17) ? 5'h00 : ls_r + 5'h01))
    else $error("slot request out of order");
  a_frame_seq: assert property (o_tx_ts_req && seen_r |->
    o_tx_frame_num == ((ls_r != 5'h17) ? lf_r : (lf_r == 4'hb) ? 4'h0 : lf_r + 4'h1))
    else $error("frame index out of order");
  a_valid_sync: assert property (o_rx_valid |-> o_rx_sync)
    else $error("receive byte without alignment");
  a_valid_pulse: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive valid longer than one cycle");
  a_rx_range: assert property (o_rx_valid |->
    o_rx_ts_num <= 5'h17 && o_rx_frame_num <= 4'hb)
    else $error("receive slot or frame out of range");
  a_sig_frames: assert property (o_rx_valid && (!(i_rbs_en || $past(i_rbs_en)) ||
    (o_rx_frame_num != 4'h5 && o_rx_frame_num != 4'hb)) |-> !o_rx_sig)
    else $error("signaling bit outside signaling frames");
endmodule // tsf_framer_sva

bind tsf_framer tsf_framer_sva chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_rbs_en(i_rbs_en), .o_line_pos(o_line_pos), .o_line_neg(o_line_neg),
  .o_tx_ts_req(o_tx_ts_req), .o_tx_ts_num(o_tx_ts_num), .o_tx_frame_num(o_tx_frame_num),
  .o_rx_valid(o_rx_valid), .o_rx_ts_num(o_rx_ts_num), .o_rx_frame_num(o_rx_frame_num),
  .o_rx_sig(o_rx_sig), .o_rx_sync(o_rx_sync));

// File: dv/tsf_line_far.sv
// Purpose: Far-end line model looping the line back to the receiver
// Assumes: One line bit per core cycle
// Notes: i_flip inverts the next mark to make a violation
`timescale 1ns/1ps
module tsf_line_far (
  input wire i_core_clk,
  input wire i_line_pos,
  input wire i_line_neg,
  input wire i_flip,
  output reg o_rx_pos,
  output reg o_rx_neg
);
  reg flip_r = 1'b0;
  initial begin
    o_rx_pos = 1'b0;
    o_rx_neg = 1'b0;
  end
  always @(posedge i_core_clk) begin
    if (flip_r && (i_line_pos || i_line_neg)) begin
      o_rx_pos <= i_line_neg;
      o_rx_neg <= i_line_pos;
      flip_r <= 1'b0;
    end else begin
      o_rx_pos <= i_line_pos;
      o_rx_neg <= i_line_neg;
      flip_r <= flip_r | i_flip;
    end
  end
endmodule // tsf_line_far

// File: dv/tb_t1_sf_framer_ami_b8zs.sv
// Purpose: Loopback bench for the T1 superframe framer
// Assumes: CLK_KHZ set so a line bit lasts one core cycle
// Notes: Far-end model echoes the line into the receiver
`timescale 1ns/1ps
module tb_t1_sf_framer_ami_b8zs;
  reg i_core_clk = 1'b0;
  reg i_reset = 1'b1;
  reg i_b8zs_en = 1'b0, i_rbs_en = 1'b0, i_tx_56k = 1'b0;
  reg [7:0] i_tx_ts_data = 8'h00;
  reg i_tx_sig = 1'b0, flip = 1'b0, zdat = 1'b0;
  wire i_rx_pos, i_rx_neg, o_line_pos, o_line_neg, o_tx_ts_req, o_rx_valid;
  wire o_rx_sig, o_rx_sync, o_rx_bpv;
  wire [4:0] o_tx_ts_num, o_rx_ts_num;
  wire [3:0] o_tx_frame_num, o_rx_frame_num;
  wire [7:0] o_rx_data;
  integer error_cnt = 0, n_tests = 0, i, k, run = 0, run_max = 0, nbpv = 0;
  reg [4:0] rows [0:5];
  // Slot the next request will name
  wire [4:0] nslot = (o_tx_ts_num == 5'h17) ? 5'h00 : o_tx_ts_num + 5'h01;
  wire [3:0] nfrm = (o_tx_ts_num != 5'h17) ? o_tx_frame_num :
    (o_tx_frame_num == 4'hb) ? 4'h0 : o_tx_frame_num + 4'h1;

  tsf_framer #(.CLK_KHZ(1544)) dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_b8zs_en(i_b8zs_en), .i_rbs_en(i_rbs_en), .i_tx_56k(i_tx_56k),
    .i_tx_ts_data(i_tx_ts_data), .i_tx_sig(i_tx_sig), .i_rx_pos(i_rx_pos),
    .i_rx_neg(i_rx_neg), .o_line_pos(o_line_pos), .o_line_neg(o_line_neg),
    .o_tx_ts_req(o_tx_ts_req), .o_tx_ts_num(o_tx_ts_num), .o_tx_frame_num(o_tx_frame_num),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_ts_num(o_rx_ts_num),
    .o_rx_frame_num(o_rx_frame_num), .o_rx_sig(o_rx_sig), .o_rx_sync(o_rx_sync),
    .o_rx_bpv(o_rx_bpv));
  tsf_line_far far (.i_core_clk(i_core_clk), .i_line_pos(o_line_pos),
    .i_line_neg(o_line_neg), .i_flip(flip), .o_rx_pos(i_rx_pos), .o_rx_neg(i_rx_neg));

  function [7:0] txb(input [4:0] s, input [3:0] f);
    txb = zdat ? 8'h00 : {1'b1, s, 1'b1, f[0]};
  endfunction
  // Expected {signaling, byte} after loopback
  function [15:0] expv(input [4:0] s, input [3:0] f);
    reg [7:0] b;
    reg sf;
    begin
      b = txb(s, f);
      sf = i_rbs_en && (f == 4'h5 || f == 4'hb);
      if (sf) b[0] = s[0] ^ f[0];
      else if (i_tx_56k) b[0] = 1'b1;
      expv = {7'h00, sf & (s[0] ^ f[0]), b};
    end
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial forever #2 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    i_tx_ts_data <= txb(nslot, nfrm);
    i_tx_sig <= nslot[0] ^ nfrm[0];
    run = (o_line_pos | o_line_neg) ? 0 : run + 1;
    if (run > run_max) run_max = run;
    if (o_rx_bpv === 1'b1) nbpv = nbpv + 1;
  end
  initial begin
    #390000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
  initial begin
    // {b8zs, rbs, 56k, zero data, check data}
    rows[0] = 5'b00001;
    rows[1] = 5'b01001;
    rows[2] = 5'b00101;
    rows[3] = 5'b11101;
    rows[4] = 5'b10011;
    rows[5] = 5'b00010;
    repeat (20) @(posedge i_core_clk);
    i_reset <= 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge i_core_clk);
      {i_b8zs_en, i_rbs_en, i_tx_56k, zdat} <= rows[i][4:1];
      repeat (3000) @(posedge i_core_clk);
      k = 0;
      while (rows[i][0] && o_rx_sync !== 1'b1 && k < 60000) begin
        @(posedge i_core_clk);
        k = k + 1;
      end
      run_max = 0;
      nbpv = 0;
      repeat (2400) begin
        @(posedge i_core_clk);
        #1;
        if (o_rx_valid === 1'b1 && rows[i][0])
          chk({o_rx_sig, o_rx_data}, expv(o_rx_ts_num, o_rx_frame_num));
      end
      if (rows[i][0]) chk(o_rx_sync, 16'h1);
      chk(run_max > 7, 16'h0);
      chk(nbpv != 0, 16'h0);
      $display("Test %0d done", i);
    end
    @(posedge i_core_clk);
    flip <= 1'b1;
    @(posedge i_core_clk);
    flip <= 1'b0;
    nbpv = 0;
    repeat (60) @(posedge i_core_clk);
    chk(nbpv != 0, 16'h1);
    $display("Test violation done");
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk({o_line_pos, o_line_neg, o_tx_ts_req, o_rx_valid, o_rx_sync, o_rx_bpv}, 16'h0);
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    k = 0;
    while (o_tx_ts_req !== 1'b1 && k < 50) begin
      @(posedge i_core_clk);
      #1;
      k = k + 1;
    end
    chk({o_tx_ts_num, o_tx_frame_num}, {7'h00, 5'h01, 4'h0});
    $display("Test reset done");
    complete_run;
  end
endmodule // tb_t1_sf_framer_ami_b8zs
